//--- common/cms_defines.svh
`ifndef CMS_DEFINES_SVH
`define CMS_DEFINES_SVH

// Register addresses, 7-bit; the control byte is {address, direction}
`define CMS_ADDR_OPST 7'h03
`define CMS_ADDR_RSTR 7'h04
`define CMS_ADDR_MASK 7'h05
`define CMS_ADDR_FLAGS 7'h06
`define CMS_ADDR_CELL_LOW 7'h08
`define CMS_ADDR_BLEED 7'h09

// Direction bit in the control byte
`define CMS_DIR_RD 1'b0
`define CMS_DIR_WR 1'b1

// Operation state codes
`define CMS_OPST_IDLE 2'h0
`define CMS_OPST_RUN 2'h1
`define CMS_OPST_DONE 2'h2
`define CMS_OPST_CANCEL 2'h3

// Field positions
`define CMS_RSTR_TMR_BIT 1
`define CMS_EV_CONV 0
`define CMS_EV_TIMER 1
`define CMS_EV_FRAME 2
`define CMS_EV_LOW 3
`define CMS_EV_CRC 4
`define CMS_FLAG_POR 5
`define CMS_FLAG_TEST 6
`define CMS_NUM_EV 5
`define CMS_NUM_FLAGS 7

// Reset values
`define CMS_OPST_RST 2'h0
`define CMS_MASK_RST 5'h00
`define CMS_FLAGS_RST 7'h20
`define CMS_RESP_RST 16'h0000

// Frame length in serial clocks, and bit counter ceiling
`define CMS_FRAME_BITS 5'h10
`define CMS_BITCNT_MAX 5'h1F

`endif

//--- common/cms_link_if.sv
`timescale 1ns/1ps
`default_nettype none

interface cms_link_if;
    import cms_pkg::*;
    // Received frame, in the system clock domain
    logic frame_done;
    logic frame_ok;
    cms_byte_t frame_ctl;
    cms_byte_t frame_data;
    // Word shifted out during the next frame
    cms_word_t resp_word;

    modport link
    (
        output frame_done, frame_ok, frame_ctl, frame_data,
        input resp_word
    );
    modport core
    (
        input frame_done, frame_ok, frame_ctl, frame_data,
        output resp_word
    );
endinterface : cms_link_if

`default_nettype wire

//--- common/cms_pkg.sv
`default_nettype none

package cms_pkg;
    // Register byte, state field, serial word and bit counter
    typedef logic [7:0] cms_byte_t;
    typedef logic [1:0] cms_opst_t;
    typedef logic [15:0] cms_word_t;
    typedef logic [4:0] cms_bitcnt_t;
endpackage : cms_pkg

`default_nettype wire

//--- logic/cms_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "cms_defines.svh"

// Behaviour
// - State field bits 1:0 shows idle 00, running 01, done 10
// - An aborted running conversion sets the state field to 11
// - Reading the state register after done or abort returns it to 00
// - Reads while running leave the state field unchanged
// - Writing 1 to soft reset bit 1 restarts the slow timer when enabled
// - Mask bits 4:0 suppress conversion, timer, frame, low cell, checksum
// - Flag bits 6:0 hold events, power-on and test mode; reset value 0x20
// - Interrupt request is high while any unmasked event flag is set
// - Reading the flag register acknowledges and clears its contents, except the test mode flag while test mode is on
// - Power-on and test mode flags never raise the interrupt request
// - A serial frame of wrong length sets the bad frame flag
// - A failed checksum check sets the checksum error flag
// - Cell low register holds one flag per cell in bits 5:0
// - A cell is flagged low when its voltage is below the threshold
// - A low cell raises the low cell event, interrupting if unmasked
// - Discharge select holds one enable per cell in bits 5:0
// - All enabled discharge outputs are driven at the same time
// - Every register access is served over the serial port
// - A finished and acknowledged conversion returns the request to idle
// - The slow timer enable gates whether a timer restart takes effect
module cms_regs
    import cms_pkg::*;
#(
    parameter int NUM_CELLS = 6,
    parameter int VOLT_W = 12
)
(
    // System clock and reset
    input wire logic clock,
    input wire logic srst,
    // Serial register port
    input wire logic spi_sclk,
    input wire logic spi_cs_n,
    input wire logic spi_mosi,
    output logic spi_miso,
    output logic spi_miso_oe,
    // Conversion sequencer events
    input wire logic conv_start,
    input wire logic conv_done,
    input wire logic conv_abort,
    output logic idle_request,
    // Slow timer, checksum and test mode
    input wire logic slow_timer_enable,
    input wire logic timer_elapsed,
    input wire logic crc_check_fail,
    input wire logic factory_test_on,
    output logic slow_timer_restart,
    // Cell measurement and balancing
    input wire logic [NUM_CELLS*VOLT_W-1:0] cell_volt,
    input wire logic cell_volt_valid,
    input wire logic [VOLT_W-1:0] low_cell_threshold,
    output logic [NUM_CELLS-1:0] cell_bleed_enable,
    // Interrupt request to the host
    output logic irq
);
    cms_link_if lnk();

    cms_opst_t operation_state_r;
    logic [`CMS_NUM_EV-1:0] interrupt_mask_r;
    logic [`CMS_NUM_FLAGS-1:0] interrupt_flags_r;
    logic [`CMS_NUM_FLAGS-1:0] interrupt_flags_nxt;
    logic [NUM_CELLS-1:0] cell_low_flags_r;
    logic [NUM_CELLS-1:0] cell_bleed_r;
    logic restart_r;
    logic idle_req_r;
    cms_word_t resp_r;
    logic [NUM_CELLS-1:0] below;
    logic [`CMS_NUM_EV-1:0] events;
    logic good_frame;
    logic rd_opst;
    logic wr_rstr;
    logic wr_mask;
    logic rd_flags;
    logic wr_bleed;
    logic frame_rd;
    cms_byte_t rd_data;

    // Serial slave with its own link clock domain
    cms_spi_link u_link
    (
        .clock(clock),
        .srst(srst),
        .spi_sclk(spi_sclk),
        .spi_cs_n(spi_cs_n),
        .spi_mosi(spi_mosi),
        .spi_miso(spi_miso),
        .spi_miso_oe(spi_miso_oe),
        .lk(lnk.link)
    );

    // Control byte match for one register and direction
    function automatic logic hit
    (
        input cms_byte_t ctl,
        input logic [6:0] addr,
        input logic dir
    );
        return ctl == {addr, dir};
    endfunction : hit

    // Access strobes for a complete, well-formed frame
    assign good_frame = lnk.frame_done & lnk.frame_ok;
    assign frame_rd = good_frame & (lnk.frame_ctl[0] == `CMS_DIR_RD);
    assign rd_opst = good_frame & hit(lnk.frame_ctl, `CMS_ADDR_OPST, `CMS_DIR_RD);
    assign wr_rstr = good_frame & hit(lnk.frame_ctl, `CMS_ADDR_RSTR, `CMS_DIR_WR);
    assign wr_mask = good_frame & hit(lnk.frame_ctl, `CMS_ADDR_MASK, `CMS_DIR_WR);
    assign rd_flags = good_frame & hit(lnk.frame_ctl, `CMS_ADDR_FLAGS, `CMS_DIR_RD);
    assign wr_bleed = good_frame & hit(lnk.frame_ctl, `CMS_ADDR_BLEED, `CMS_DIR_WR);

    // Per-cell comparison against the low cell threshold
    generate
        for (genvar i = 0; i < NUM_CELLS; i++)
        begin : g_cell
            assign below[i] = cell_volt[i*VOLT_W +: VOLT_W] < low_cell_threshold;
        end
    endgenerate

    // Event sources feeding the sticky flags
    always_comb
    begin
        events = '0;
        events[`CMS_EV_CONV] = conv_done && (operation_state_r == `CMS_OPST_RUN);
        events[`CMS_EV_TIMER] = timer_elapsed;
        events[`CMS_EV_FRAME] = lnk.frame_done & ~lnk.frame_ok;
        events[`CMS_EV_LOW] = cell_volt_valid & (|below);
        events[`CMS_EV_CRC] = crc_check_fail;
    end

    // Operation state field; hardware events take priority over the read
    always_ff @(posedge clock)
    begin
        if (srst)
            operation_state_r <= `CMS_OPST_RST;
        else if (conv_abort && operation_state_r == `CMS_OPST_RUN)
            operation_state_r <= `CMS_OPST_CANCEL;
        else if (conv_done && operation_state_r == `CMS_OPST_RUN)
            operation_state_r <= `CMS_OPST_DONE;
        else if (conv_start && operation_state_r != `CMS_OPST_RUN)
            operation_state_r <= `CMS_OPST_RUN;
        else if (rd_opst && operation_state_r != `CMS_OPST_RUN)
            operation_state_r <= `CMS_OPST_IDLE;
    end

    // Interrupt mask, written whole from the low data bits
    always_ff @(posedge clock)
    begin
        if (srst)
            interrupt_mask_r <= `CMS_MASK_RST;
        else if (wr_mask)
            interrupt_mask_r <= lnk.frame_data[`CMS_NUM_EV-1:0];
    end

    // Flag next value: a read clears, then new events are ORed back in
    always_comb
    begin
        interrupt_flags_nxt = rd_flags ? '0 : interrupt_flags_r;
        interrupt_flags_nxt[`CMS_NUM_EV-1:0] =
            interrupt_flags_nxt[`CMS_NUM_EV-1:0] | events;
        if (factory_test_on)
            interrupt_flags_nxt[`CMS_FLAG_TEST] = 1'b1;
    end

    // Flag register; power-on flag comes out of reset set
    always_ff @(posedge clock)
    begin
        if (srst)
            interrupt_flags_r <= `CMS_FLAGS_RST;
        else
            interrupt_flags_r <= interrupt_flags_nxt;
    end

    // Request from unmasked event flags only, never power-on or test
    assign irq = |(interrupt_flags_r[`CMS_NUM_EV-1:0] & ~interrupt_mask_r);

    // Latest per-cell low result
    always_ff @(posedge clock)
    begin
        if (srst)
            cell_low_flags_r <= '0;
        else if (cell_volt_valid)
            cell_low_flags_r <= below;
    end

    // Discharge enables, all driven in parallel
    always_ff @(posedge clock)
    begin
        if (srst)
            cell_bleed_r <= '0;
        else if (wr_bleed)
            cell_bleed_r <= lnk.frame_data[NUM_CELLS-1:0];
    end

    assign cell_bleed_enable = cell_bleed_r;

    // Slow timer restart pulse, only while the timer is enabled
    always_ff @(posedge clock)
    begin
        if (srst)
            restart_r <= 1'b0;
        else
            restart_r <= wr_rstr && lnk.frame_data[`CMS_RSTR_TMR_BIT]
                && slow_timer_enable;
    end

    assign slow_timer_restart = restart_r;

    // Return the operation request to idle once done is acknowledged
    always_ff @(posedge clock)
    begin
        if (srst)
            idle_req_r <= 1'b0;
        else
            idle_req_r <= rd_flags && interrupt_flags_r[`CMS_EV_CONV];
    end

    assign idle_request = idle_req_r;

    // Read data multiplexer, unmapped or write-only addresses read zero
    always_comb
    begin
        rd_data = 8'h00;
        unique case (lnk.frame_ctl[7:1])
            `CMS_ADDR_OPST: rd_data = {6'h00, operation_state_r};
            `CMS_ADDR_MASK: rd_data = {3'h0, interrupt_mask_r};
            `CMS_ADDR_FLAGS: rd_data = {1'b0, interrupt_flags_r};
            `CMS_ADDR_CELL_LOW: rd_data = 8'(cell_low_flags_r);
            `CMS_ADDR_BLEED: rd_data = 8'(cell_bleed_r);
            default: rd_data = 8'h00;
        endcase
    end

    // Answer for the next frame: echoed control byte and the read value, or the written data byte for a write
    always_ff @(posedge clock)
    begin
        if (srst)
            resp_r <= `CMS_RESP_RST;
        else if (frame_rd)
            resp_r <= {lnk.frame_ctl, rd_data};
        else if (good_frame)
            resp_r <= {lnk.frame_ctl, lnk.frame_data};
    end

    assign lnk.resp_word = resp_r;
endmodule : cms_regs

`default_nettype wire

//--- logic/cms_spi_link.sv
`timescale 1ns/1ps
`default_nettype none
`include "cms_defines.svh"

module cms_spi_link
    import cms_pkg::*;
(
    // System clock and reset
    input wire logic clock,
    input wire logic srst,
    // Serial pins
    input wire logic spi_sclk,
    input wire logic spi_cs_n,
    input wire logic spi_mosi,
    output logic spi_miso,
    output logic spi_miso_oe,
    // Frame carrier towards the register core
    cms_link_if.link lk
);
    logic first_r;
    logic seq_r;
    logic miso_r;
    cms_bitcnt_t cnt_r;
    cms_word_t sh_r;
    cms_word_t osh_r;
    logic cs_s1_r;
    logic cs_s2_r;
    logic cs_s3_r;
    logic seen_r;

    // Armed while select is high, so the next edge starts a frame
    always_ff @(posedge spi_sclk or posedge spi_cs_n)
    begin
        if (spi_cs_n)
            first_r <= 1'b1;
        else
            first_r <= 1'b0;
    end

    // Frame sequence toggle, one flip per frame
    always_ff @(posedge spi_sclk or posedge srst)
    begin
        if (srst)
            seq_r <= 1'b0;
        else if (first_r)
            seq_r <= ~seq_r;
    end

    // Input shift and saturating bit count on the link clock
    always_ff @(posedge spi_sclk)
    begin
        if (first_r)
        begin
            cnt_r <= 5'h01;
            sh_r <= {15'h0000, spi_mosi};
        end
        else
        begin
            if (cnt_r != `CMS_BITCNT_MAX)
                cnt_r <= cnt_r + 5'h01;
            sh_r <= {sh_r[14:0], spi_mosi};
        end
    end

    // Output shift; the response word is static between frames
    always_ff @(posedge spi_sclk)
    begin
        if (first_r)
            osh_r <= {lk.resp_word[14:0], 1'b0};
        else
            osh_r <= {osh_r[14:0], 1'b0};
    end

    // Serial output bit, parked low outside frames
    always_ff @(posedge spi_sclk or posedge spi_cs_n)
    begin
        if (spi_cs_n)
            miso_r <= 1'b0;
        else if (first_r)
            miso_r <= lk.resp_word[15];
        else
            miso_r <= osh_r[15];
    end

    assign spi_miso = miso_r;
    assign spi_miso_oe = ~first_r; // Drive from first edge to select release

    // Select synchroniser and edge history
    always_ff @(posedge clock)
    begin
        cs_s1_r <= spi_cs_n;
        cs_s2_r <= cs_s1_r;
        cs_s3_r <= cs_s2_r;
    end

    // Frame hand-over once select has risen and link flops are frozen
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            seen_r <= 1'b0;
            lk.frame_done <= 1'b0;
            lk.frame_ok <= 1'b0;
            lk.frame_ctl <= 8'h00;
            lk.frame_data <= 8'h00;
        end
        else
        begin
            lk.frame_done <= 1'b0;
            if (cs_s2_r && !cs_s3_r && (seq_r != seen_r))
            begin
                seen_r <= seq_r;
                lk.frame_done <= 1'b1;
                lk.frame_ok <= (cnt_r == `CMS_FRAME_BITS);
                lk.frame_ctl <= sh_r[15:8];
                lk.frame_data <= sh_r[7:0];
            end
        end
    end
endmodule : cms_spi_link

`default_nettype wire

//--- testbench/cms_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module cms_host_model
    import cms_pkg::*;
(
    // Serial pins towards the device
    output var logic spi_sclk,
    output var logic spi_cs_n,
    output var logic spi_mosi,
    input wire logic spi_miso
);
    // Idle: clock low and still, not selected
    initial
    begin
        spi_sclk = 1'b0;
        spi_cs_n = 1'b0;
        spi_mosi = 1'b0;
        // Rising select after time zero, so the link's asynchronous set is seen
        #1 spi_cs_n = 1'b1;
    end
    // One frame of n bits, MSB first, answer sampled on falling clock
    task automatic xfer(input cms_word_t w, input int n, output cms_word_t r);
        r = 16'h0000;
        spi_cs_n = 1'b0;
        #20;
        for (int i = 0; i < n; i++)
        begin
            spi_mosi = w[15 - i];
            #3 spi_sclk = 1'b1;
            #3 spi_sclk = 1'b0;
            r = {r[14:0], spi_miso};
        end
        #20 spi_cs_n = 1'b1;
        // Released data line shows the inverse of the last bit
        spi_mosi = ~spi_mosi;
        #800;
    endtask : xfer
endmodule : cms_host_model

`default_nettype wire

//--- testbench/cms_regs_props.sv
`timescale 1ns/1ps
`default_nettype none

module cms_regs_props
    import cms_pkg::*;
#(
    parameter int NUM_CELLS = 6,
    parameter int VOLT_W = 12
)
(
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Serial pins
    input wire logic spi_cs_n,
    input wire logic spi_miso,
    input wire logic spi_miso_oe,
    // Events and outputs
    input wire logic conv_done,
    input wire logic timer_elapsed,
    input wire logic crc_check_fail,
    input wire logic cell_volt_valid,
    input wire logic slow_timer_enable,
    input wire logic slow_timer_restart,
    input wire logic idle_request,
    input wire logic [NUM_CELLS-1:0] cell_bleed_enable,
    input wire logic irq
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (srst);
    logic [2:0] ev_r;
    // Event pulses of the last three cycles
    always_ff @(posedge clock)
    begin
        ev_r <= {ev_r[1:0], conv_done | timer_elapsed | crc_check_fail | cell_volt_valid};
    end
    reset_clear_a: assert property (
        $past(srst) |-> !irq && cell_bleed_enable == '0 && !slow_timer_restart && !idle_request)
        else $error("outputs not cleared by reset");
    restart_gate_a: assert property (
        slow_timer_restart |-> $past(slow_timer_enable))
        else $error("timer restart while disabled");
    restart_only_a: assert property (
        spi_cs_n [*8] |=> !slow_timer_restart)
        else $error("timer restart without a frame");
    idle_only_a: assert property (
        spi_cs_n [*8] |=> !idle_request)
        else $error("idle request without a flag read");
    bleed_hold_a: assert property (
        spi_cs_n [*8] |=> $stable(cell_bleed_enable))
        else $error("discharge outputs changed without a frame");
    irq_cause_a: assert property (
        spi_cs_n [*8] ##0 $rose(irq) |-> |ev_r)
        else $error("interrupt raised without an event");
    irq_hold_a: assert property (
        spi_cs_n [*8] |=> !$fell(irq) || $past(srst))
        else $error("interrupt dropped without a frame");
    miso_idle_a: assert property (
        spi_cs_n [*2] |-> !spi_miso && !spi_miso_oe)
        else $error("serial output driven while deselected");
endmodule : cms_regs_props

bind cms_regs cms_regs_props #(.NUM_CELLS(NUM_CELLS), .VOLT_W(VOLT_W)) u_props
(
    .clock(clock), .srst(srst), .spi_cs_n(spi_cs_n), .spi_miso(spi_miso),
    .spi_miso_oe(spi_miso_oe), .conv_done(conv_done), .timer_elapsed(timer_elapsed),
    .crc_check_fail(crc_check_fail), .cell_volt_valid(cell_volt_valid),
    .slow_timer_enable(slow_timer_enable), .slow_timer_restart(slow_timer_restart),
    .idle_request(idle_request), .cell_bleed_enable(cell_bleed_enable), .irq(irq)
);

`default_nettype wire

//--- testbench/test_cms_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "cms_defines.svh"

module test_cms_regs
    import cms_pkg::*;
;
    logic clock, srst, sclk, cs_n, mosi, miso, oe, idle, ste, fto, rsp, irq;
    logic idle_seen, rst_seen;
    logic [5:0] pls, bleed;
    logic [71:0] volt;
    logic [11:0] thr;
    cms_word_t r;
    int fails, check_count;

    // Device under test
    cms_regs dut
    (
        .clock(clock), .srst(srst), .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_mosi(mosi),
        .spi_miso(miso), .spi_miso_oe(oe), .conv_start(pls[0]), .conv_done(pls[1]),
        .conv_abort(pls[2]), .idle_request(idle), .slow_timer_enable(ste),
        .timer_elapsed(pls[3]), .crc_check_fail(pls[4]), .factory_test_on(fto),
        .slow_timer_restart(rsp), .cell_volt(volt), .cell_volt_valid(pls[5]),
        .low_cell_threshold(thr), .cell_bleed_enable(bleed), .irq(irq)
    );
    // Host on the serial port; data line reads low when undriven
    cms_host_model host
    (
        .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_mosi(mosi), .spi_miso(miso & oe)
    );

    // System clock
    always #50 clock = ~clock;
    // Catch single-cycle output pulses
    always @(posedge clock)
    begin
        if (idle === 1'b1) idle_seen <= 1'b1;
        if (rsp === 1'b1) rst_seen <= 1'b1;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp)
        begin
            fails++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [6:0] a, input cms_byte_t d);
        host.xfer({a, `CMS_DIR_WR, d}, 16, r);
    endtask : wr
    // Read, then fetch the answer with a harmless mask read
    task automatic rdc(input logic [6:0] a, input cms_byte_t e);
        host.xfer({a, `CMS_DIR_RD, 8'h00}, 16, r);
        host.xfer({`CMS_ADDR_MASK, `CMS_DIR_RD, 8'h00}, 16, r);
        chk(r[15:8], {a, `CMS_DIR_RD});
        chk(r[7:0], e);
    endtask : rdc
    task automatic pulse(input int k);
        @(posedge clock) pls <= 6'h01 << k;
        @(posedge clock) pls <= 6'h00;
        repeat (3) @(posedge clock);
    endtask : pulse

    task automatic t_reset();
        rdc(`CMS_ADDR_FLAGS, 8'h20);
        rdc(`CMS_ADDR_FLAGS, 8'h00);
        rdc(`CMS_ADDR_OPST, 8'h00);
        rdc(`CMS_ADDR_MASK, 8'h00);
        rdc(`CMS_ADDR_BLEED, 8'h00);
        rdc(7'h07, 8'h00);
        chk({7'h00, irq}, 8'h00);
        $display("reset test done");
    endtask : t_reset
    task automatic t_opstate();
        pulse(0);
        rdc(`CMS_ADDR_OPST, 8'h01);
        rdc(`CMS_ADDR_OPST, 8'h01);
        pulse(1);
        rdc(`CMS_ADDR_OPST, 8'h02);
        chk({7'h00, irq}, 8'h01);
        idle_seen = 1'b0;
        rdc(`CMS_ADDR_FLAGS, 8'h01);
        chk({7'h00, idle_seen}, 8'h01);
        chk({7'h00, irq}, 8'h00);
        rdc(`CMS_ADDR_OPST, 8'h00);
        pulse(0);
        pulse(2);
        rdc(`CMS_ADDR_OPST, 8'h03);
        rdc(`CMS_ADDR_OPST, 8'h00);
        $display("state test done");
    endtask : t_opstate
    // Each event masked, then unmasked, then read and cleared
    task automatic t_events();
        for (int i = 0; i < 5; i++)
        begin
            wr(`CMS_ADDR_MASK, 8'h01 << i);
            case (i)
                0:
                begin
                    pulse(0);
                    pulse(1);
                end
                1: pulse(3);
                2: host.xfer(16'hFFFF, 12, r);
                3:
                begin
                    @(posedge clock);
                    volt[11:0] <= 12'h100;
                    volt[35:24] <= 12'h56F;
                    pulse(5);
                end
                default: pulse(4);
            endcase
            chk({7'h00, irq}, 8'h00);
            wr(`CMS_ADDR_MASK, 8'h00);
            chk({7'h00, irq}, 8'h01);
            rdc(`CMS_ADDR_FLAGS, 8'h01 << i);
            chk({7'h00, irq}, 8'h00);
        end
        rdc(`CMS_ADDR_OPST, 8'h02);
        @(posedge clock) fto <= 1'b1;
        pulse(3);
        wr(`CMS_ADDR_MASK, 8'h1F);
        rdc(`CMS_ADDR_FLAGS, 8'h42);
        // Unmask all: only the test mode flag is left, which must not interrupt
        wr(`CMS_ADDR_MASK, 8'h00);
        chk({7'h00, irq}, 8'h00);
        @(posedge clock) fto <= 1'b0;
        $display("event test done");
    endtask : t_events
    task automatic t_cells();
        rdc(`CMS_ADDR_CELL_LOW, 8'h05);
        wr(`CMS_ADDR_BLEED, 8'h2A);
        chk({2'b00, bleed}, 8'h2A);
        rdc(`CMS_ADDR_BLEED, 8'h2A);
        wr(`CMS_ADDR_BLEED, 8'h3F);
        chk({2'b00, bleed}, 8'h3F);
        wr(`CMS_ADDR_CELL_LOW, 8'h00);
        rdc(`CMS_ADDR_CELL_LOW, 8'h05);
        // Lower the threshold so only the first cell stays below it
        @(posedge clock) thr <= 12'h101;
        pulse(5);
        rdc(`CMS_ADDR_CELL_LOW, 8'h01);
        $display("cell test done");
    endtask : t_cells
    task automatic t_restart();
        @(posedge clock) ste <= 1'b1;
        rst_seen = 1'b0;
        wr(`CMS_ADDR_RSTR, 8'h02);
        chk({7'h00, rst_seen}, 8'h01);
        rst_seen = 1'b0;
        wr(`CMS_ADDR_RSTR, 8'h01);
        chk({7'h00, rst_seen}, 8'h00);
        @(posedge clock) ste <= 1'b0;
        wr(`CMS_ADDR_RSTR, 8'h02);
        chk({7'h00, rst_seen}, 8'h00);
        $display("restart test done");
    endtask : t_restart

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : report_and_stop

    // Watchdog well beyond the expected run time
    initial
    begin
        #400000;
        fails++;
        report_and_stop();
    end
    // Main sequence
    initial
    begin
        clock = 1'b0;
        srst = 1'b0;
        pls = 6'h00;
        ste = 1'b0;
        fto = 1'b0;
        volt = {6{12'hFFF}};
        thr = 12'h570;
        // Raise reset on an edge so the link's asynchronous clear sees it rise
        @(posedge clock) srst <= 1'b1;
        repeat (12) @(posedge clock);
        srst <= 1'b0;
        repeat (2) @(posedge clock);
        t_reset();
        t_opstate();
        t_events();
        t_cells();
        t_restart();
        report_and_stop();
    end
endmodule : test_cms_regs

`default_nettype wire
